// *** pkg/prr_mem_if.sv ***
// Read request channel between the sequencer and the memory port
`timescale 1ns/1ns
interface prr_mem_if;
  logic        req;
  logic [31:0] addr;
  logic        done;
  logic [31:0] rdata;

  modport master (output req, output addr, input done, input rdata);
  modport port   (input req, input addr, output done, output rdata);
endinterface : prr_mem_if

// *** pkg/prr_pkg.sv ***
// Constants, states and state records for the return and resume unit
package prr_pkg;

  // ----------------------------------------------------------------
  // Register byte offsets
  // ----------------------------------------------------------------
  localparam logic [7:0] REG_COMMAND  = 8'h00;
  localparam logic [7:0] REG_OPERAND  = 8'h04;
  localparam logic [7:0] REG_FRAME    = 8'h08;
  localparam logic [7:0] REG_INSTR    = 8'h0C;
  localparam logic [7:0] REG_ARITH    = 8'h10;
  localparam logic [7:0] REG_PROC     = 8'h14;
  localparam logic [7:0] REG_STATUS   = 8'h18;
  localparam logic [7:0] REG_PCB_BASE = 8'h1C;

  // ----------------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------------
  localparam int CMD_RET_BIT    = 0;
  localparam int CMD_RESUME_BIT = 1;
  localparam int CMD_PCB_BIT    = 2;
  localparam int PC_TRACE_BIT   = 0;
  localparam int PC_SUPER_BIT   = 1;
  localparam int ST_BUSY_BIT    = 0;
  localparam int ST_IDLE_BIT    = 1;
  localparam int ST_FAULT_BIT   = 2;
  localparam int ST_FCODE_LO    = 3;
  localparam int ST_RSTAT_LO    = 8;

  // ----------------------------------------------------------------
  // Frame layout and masks
  // ----------------------------------------------------------------
  localparam logic [31:0] OFS_SAVED_PC = 32'hFFFF_FFF0;
  localparam logic [31:0] OFS_SAVED_AC = 32'hFFFF_FFF4;
  localparam logic [31:0] OFS_RIP      = 32'h0000_0008;
  localparam logic [31:0] FRAME_MASK   = 32'hFFFF_FFF0;
  localparam logic [31:0] IP_MASK      = 32'hFFFF_FFFC;

  // ----------------------------------------------------------------
  // Values after reset
  // ----------------------------------------------------------------
  localparam logic [31:0] RST_FP = 32'h0000_0000;
  localparam logic [31:0] RST_PC = 32'h0000_0002;

  // ----------------------------------------------------------------
  // Return status codes and fault codes
  // ----------------------------------------------------------------
  localparam logic [2:0] RS_FRAME  = 3'h0;
  localparam logic [2:0] RS_RESTOR = 3'h1;
  localparam logic [2:0] RS_USER_T0 = 3'h2;
  localparam logic [2:0] RS_USER_T1 = 3'h3;
  localparam logic [2:0] RS_IDLE   = 3'h6;
  localparam logic [2:0] RS_RESTIR = 3'h7;
  localparam logic [1:0] FC_NONE   = 2'h0;
  localparam logic [1:0] FC_TYPE   = 2'h1;
  localparam logic [1:0] FC_PRIV   = 2'h2;

  typedef enum logic [3:0] {
    S_IDLE   = 4'h0,
    S_DRAIN  = 4'h1,
    S_RD_R0  = 4'h3,
    S_RD_X   = 4'h2,
    S_RD_Y   = 4'h6,
    S_FREE   = 4'h7,
    S_FILL   = 4'h5,
    S_RD_RIP = 4'h4,
    S_FINISH = 4'hC,
    S_HALT   = 4'hD,
    S_BIND   = 4'h8
  } prr_state_t;

  typedef struct packed {
    prr_state_t  state;
    logic        issued;
    logic        busy;
    logic [31:0] fp;
    logic [31:0] previous_frame_pointer;
    logic [31:0] ip;
    logic [31:0] ac;
    logic [31:0] pc;
    logic [31:0] operand;
    logic [31:0] pcb_base;
    logic [3:0]  rstat;
    logic [31:0] saved_x;
    logic [31:0] saved_y;
    logic        fault;
    logic [1:0]  fcode;
    logic        idle;
    logic        regset_free;
    logic        regset_fill;
    logic        cache_discard;
    logic        irq_check;
    logic        mem_go;
    logic [31:0] mem_addr;
    logic        pready;
    logic        pslverr;
    logic [31:0] prdata;
  } prr_top_state_t;

  typedef struct packed {
    logic        mem_req;
    logic [31:0] mem_addr;
    logic        done;
    logic [31:0] rdata;
  } prr_port_state_t;

endpackage : prr_pkg

// *** rtl/prr_mem_port.sv ***
// Memory read port: holds one request on the pins until acknowledged
`timescale 1ns/1ns
module prr_mem_port (
  input  wire logic   clk,       // Core clock
  input  wire logic   rst_n,     // Asynchronous reset, active low
  prr_mem_if.port     link,      // Requests from the sequencer
  output logic        mem_req,   // Read request, held until ack
  output logic [31:0] mem_addr,  // Read byte address
  input  wire logic   mem_ack,   // Read data valid, one cycle
  input  wire logic [31:0] mem_rdata  // Read data
);

  prr_pkg::prr_port_state_t s;
  prr_pkg::prr_port_state_t next_s;

  always_comb begin
    next_s      = s;
    next_s.done = 1'b0;
    // A request that lands while one is open is dropped; the sequencer never does that
    if (!s.mem_req && link.req) begin
      next_s.mem_req  = 1'b1;
      next_s.mem_addr = link.addr;
    end else if (s.mem_req && mem_ack) begin
      next_s.mem_req = 1'b0;
      next_s.done    = 1'b1;
      next_s.rdata   = mem_rdata;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      s <= '0;
    end else begin
      s <= next_s;
    end
  end

  assign mem_req    = s.mem_req;
  assign mem_addr   = s.mem_addr;
  assign link.done  = s.done;
  assign link.rdata = s.rdata;

endmodule : prr_mem_port

// *** rtl/prr_top.sv ***
// Procedure return and process resume sequencer with APB registers
// ------------------------------------------------------------------
// Operation
// - Resume with a non process block operand faults, else binds the new process.
// - Resume discards cached process state, no write back, no unlock.
// - Resume is accepted only in supervisor mode.
// - Return waits until all earlier uncompleted instructions finish.
// - Return status and trace flag come from bits 0 to 3 of local r0.
// - Return drops the frame; all but status 110 in supervisor load frame pointer from previous frame pointer.
// - Status 000 frees the register set and reloads it if not allocated.
// - Return, except status 110 in supervisor, resumes fetching at the saved return instruction pointer.
// - Status 001 restores arithmetic controls, process controls only in supervisor.
// - Status 010 or 011 in supervisor sets trace 0 or 1 and goes user.
// - Status 110 in supervisor frees registers, checks interrupts, else idles.
// - Status 111 acts as 001 then checks pending interrupts in supervisor.
// ------------------------------------------------------------------
`timescale 1ns/1ns
module prr_top (
  input  wire logic        clk,           // Core clock, 125 MHz
  input  wire logic        rst_n,         // Asynchronous reset, active low
  input  wire logic        psel,          // APB select
  input  wire logic        penable,       // APB access phase
  input  wire logic        pwrite,        // APB write
  input  wire logic [7:0]  paddr,         // APB byte address
  input  wire logic [31:0] pwdata,        // APB write data
  output logic [31:0]      prdata,        // APB read data
  output logic             pready,        // APB ready
  output logic             pslverr,       // APB error on unmapped address
  input  wire logic        pending_ops,   // Earlier instructions still running
  input  wire logic        irq_pending,   // An interrupt is waiting
  input  wire logic        regset_hit,    // Register set for regset_addr is on chip
  input  wire logic        fill_done,     // Register set reload finished
  output logic [31:0]      regset_addr,   // Frame pointer for set lookup and reload
  output logic             regset_free,   // Free the current set, one cycle
  output logic             regset_fill,   // Reload the set from memory, one cycle
  output logic             cache_discard, // Drop cached process state, one cycle
  output logic             irq_check,     // Check pending interrupts, one cycle
  output logic             idle,          // Core idles until an interrupt
  output logic             fault,         // Sticky fault
  output logic             busy,          // Sequence in progress
  output logic             mem_req,       // Memory read request
  output logic [31:0]      mem_addr,      // Memory read address
  input  wire logic        mem_ack,       // Memory read answer
  input  wire logic [31:0] mem_rdata      // Memory read data
);

  // ----------------------------------------------------------------
  // State and memory channel
  // ----------------------------------------------------------------
  prr_pkg::prr_top_state_t s;
  prr_pkg::prr_top_state_t next_s;

  prr_mem_if mem ();

  prr_mem_port u_port (
    .clk       (clk),
    .rst_n     (rst_n),
    .link      (mem),
    .mem_req   (mem_req),
    .mem_addr  (mem_addr),
    .mem_ack   (mem_ack),
    .mem_rdata (mem_rdata)
  );

  assign mem.req  = s.mem_go;
  assign mem.addr = s.mem_addr;

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  logic        access;
  logic        wr_commit;
  logic        sup_mode;
  logic        rd_state;
  logic [31:0] rd_addr;
  logic [31:0] status_word;
  logic [2:0]  rs;

  assign access    = psel && penable;
  assign wr_commit = access && s.pready && pwrite;
  assign sup_mode  = s.pc[prr_pkg::PC_SUPER_BIT];
  assign rs        = s.rstat[2:0];

  always_comb begin
    status_word = '0;
    status_word[prr_pkg::ST_BUSY_BIT]  = s.busy;
    status_word[prr_pkg::ST_IDLE_BIT]  = s.idle;
    status_word[prr_pkg::ST_FAULT_BIT] = s.fault;
    status_word[prr_pkg::ST_FCODE_LO +: 2] = s.fcode;
    status_word[prr_pkg::ST_RSTAT_LO +: 4] = s.rstat;
  end

  always_comb begin
    rd_state = 1'b1;
    rd_addr  = s.fp;
    case (s.state)
      prr_pkg::S_RD_R0:  rd_addr = s.fp;
      prr_pkg::S_RD_X:   rd_addr = s.fp + prr_pkg::OFS_SAVED_PC;
      prr_pkg::S_RD_Y:   rd_addr = s.fp + prr_pkg::OFS_SAVED_AC;
      prr_pkg::S_RD_RIP: rd_addr = s.fp + prr_pkg::OFS_RIP;
      default:           rd_state = 1'b0;
    endcase
  end

  // ----------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------
  always_comb begin
    next_s               = s;
    next_s.regset_free   = 1'b0;
    next_s.regset_fill   = 1'b0;
    next_s.cache_discard = 1'b0;
    next_s.irq_check     = 1'b0;
    next_s.mem_go        = 1'b0;
    next_s.pready        = 1'b0;
    next_s.pslverr       = 1'b0;

    // APB: decode in the first access cycle, commit at the ready edge
    if (access && !s.pready) begin
      next_s.pready = 1'b1;
      next_s.prdata = '0;
      if (paddr == prr_pkg::REG_COMMAND) begin
        next_s.prdata = '0;
      end else if (paddr == prr_pkg::REG_OPERAND) begin
        next_s.prdata = s.operand;
      end else if (paddr == prr_pkg::REG_FRAME) begin
        next_s.prdata = s.fp;
      end else if (paddr == prr_pkg::REG_INSTR) begin
        next_s.prdata = s.ip;
      end else if (paddr == prr_pkg::REG_ARITH) begin
        next_s.prdata = s.ac;
      end else if (paddr == prr_pkg::REG_PROC) begin
        next_s.prdata = s.pc;
      end else if (paddr == prr_pkg::REG_STATUS) begin
        next_s.prdata = status_word;
      end else if (paddr == prr_pkg::REG_PCB_BASE) begin
        next_s.prdata = s.pcb_base;
      end else begin
        next_s.pslverr = 1'b1;
      end
      if (pwrite) begin
        next_s.prdata = '0;
      end
    end

    // Context registers change only while no sequence runs
    if (wr_commit && s.state == prr_pkg::S_IDLE) begin
      if (paddr == prr_pkg::REG_COMMAND) begin
        if (pwdata[prr_pkg::CMD_RET_BIT]) begin
          next_s.state = prr_pkg::S_DRAIN;
        end else if (pwdata[prr_pkg::CMD_RESUME_BIT]) begin
          if (!sup_mode) begin
            next_s.fault = 1'b1;
            next_s.fcode = prr_pkg::FC_PRIV;
          end else if (!pwdata[prr_pkg::CMD_PCB_BIT]) begin
            next_s.fault = 1'b1;
            next_s.fcode = prr_pkg::FC_TYPE;
          end else begin
            next_s.state = prr_pkg::S_BIND;
          end
        end
      end else if (paddr == prr_pkg::REG_OPERAND) begin
        next_s.operand = pwdata;
      end else if (paddr == prr_pkg::REG_FRAME) begin
        next_s.fp = pwdata;
      end else if (paddr == prr_pkg::REG_ARITH) begin
        next_s.ac = pwdata;
      end else if (paddr == prr_pkg::REG_PROC) begin
        next_s.pc = pwdata;
      end
    end
    // Fault clears by writing one; a fault raised above in this cycle still wins
    if (wr_commit && paddr == prr_pkg::REG_STATUS && pwdata[prr_pkg::ST_FAULT_BIT]
        && next_s.fault == s.fault) begin
      next_s.fault = 1'b0;
      next_s.fcode = prr_pkg::FC_NONE;
    end

    // Memory reads: issue once on entry, then wait for the answer
    if (rd_state && !s.issued) begin
      next_s.mem_go   = 1'b1;
      next_s.mem_addr = rd_addr;
      next_s.issued   = 1'b1;
    end

    case (s.state)
      prr_pkg::S_IDLE: begin
        next_s.issued = 1'b0;
      end
      prr_pkg::S_DRAIN: begin
        if (!pending_ops) begin
          next_s.state  = prr_pkg::S_RD_R0;
          next_s.issued = 1'b0;
        end
      end
      prr_pkg::S_RD_R0: begin
        if (s.issued && mem.done) begin
          next_s.issued = 1'b0;
          next_s.rstat  = mem.rdata[3:0];
          next_s.previous_frame_pointer    = mem.rdata & prr_pkg::FRAME_MASK;
          case (mem.rdata[2:0])
            prr_pkg::RS_RESTOR, prr_pkg::RS_RESTIR: begin
              next_s.state = prr_pkg::S_RD_X;
            end
            prr_pkg::RS_USER_T0, prr_pkg::RS_USER_T1: begin
              if (sup_mode) begin
                next_s.pc[prr_pkg::PC_TRACE_BIT] = mem.rdata[0];
                next_s.pc[prr_pkg::PC_SUPER_BIT] = 1'b0;
              end
              next_s.state = prr_pkg::S_FREE;
            end
            prr_pkg::RS_IDLE: begin
              if (sup_mode) begin
                next_s.regset_free = 1'b1;
                next_s.irq_check   = 1'b1;
                if (irq_pending) begin
                  next_s.state = prr_pkg::S_IDLE;
                end else begin
                  next_s.idle  = 1'b1;
                  next_s.state = prr_pkg::S_HALT;
                end
              end else begin
                next_s.state = prr_pkg::S_FREE;
              end
            end
            default: begin
              next_s.state = prr_pkg::S_FREE;
            end
          endcase
        end
      end
      prr_pkg::S_RD_X: begin
        if (s.issued && mem.done) begin
          next_s.saved_x = mem.rdata;
          next_s.issued  = 1'b0;
          next_s.state   = prr_pkg::S_RD_Y;
        end
      end
      prr_pkg::S_RD_Y: begin
        if (s.issued && mem.done) begin
          next_s.saved_y = mem.rdata;
          next_s.issued  = 1'b0;
          next_s.state   = prr_pkg::S_FREE;
        end
      end
      prr_pkg::S_FREE: begin
        next_s.fp          = s.previous_frame_pointer;
        next_s.regset_free = 1'b1;
        next_s.issued      = 1'b0;
        next_s.state       = prr_pkg::S_FILL;
      end
      prr_pkg::S_FILL: begin
        // Lookup is answered for regset_addr, which already holds the new frame
        if (!s.issued) begin
          if (regset_hit) begin
            next_s.state = prr_pkg::S_RD_RIP;
          end else begin
            next_s.regset_fill = 1'b1;
            next_s.issued      = 1'b1;
          end
        end else if (fill_done) begin
          next_s.issued = 1'b0;
          next_s.state  = prr_pkg::S_RD_RIP;
        end
      end
      prr_pkg::S_RD_RIP: begin
        if (s.issued && mem.done) begin
          next_s.ip     = mem.rdata & prr_pkg::IP_MASK;
          next_s.issued = 1'b0;
          next_s.state  = prr_pkg::S_FINISH;
        end
      end
      prr_pkg::S_FINISH: begin
        if (rs == prr_pkg::RS_RESTOR || rs == prr_pkg::RS_RESTIR) begin
          next_s.ac = s.saved_y;
          if (sup_mode) begin
            next_s.pc = s.saved_x;
            if (rs == prr_pkg::RS_RESTIR) begin
              next_s.irq_check = 1'b1;
            end
          end
        end
        next_s.state = prr_pkg::S_IDLE;
      end
      prr_pkg::S_HALT: begin
        if (irq_pending) begin
          next_s.idle      = 1'b0;
          next_s.irq_check = 1'b1;
          next_s.state     = prr_pkg::S_IDLE;
        end
      end
      prr_pkg::S_BIND: begin
        next_s.cache_discard = 1'b1;
        next_s.pcb_base      = s.operand;
        next_s.state         = prr_pkg::S_IDLE;
      end
      default: begin
        next_s.state = prr_pkg::S_IDLE;
      end
    endcase

    next_s.busy = (next_s.state != prr_pkg::S_IDLE);
  end

  // ----------------------------------------------------------------
  // State register
  // ----------------------------------------------------------------
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      s    <= '0;
      s.fp <= prr_pkg::RST_FP;
      s.pc <= prr_pkg::RST_PC;
    end else begin
      s <= next_s;
    end
  end

  assign prdata        = s.prdata;
  assign pready        = s.pready;
  assign pslverr       = s.pslverr;
  assign regset_addr   = s.fp;
  assign regset_free   = s.regset_free;
  assign regset_fill   = s.regset_fill;
  assign cache_discard = s.cache_discard;
  assign irq_check     = s.irq_check;
  assign idle          = s.idle;
  assign fault         = s.fault;
  assign busy          = s.busy;

endmodule : prr_top

// *** tb/prr_assertions.sv ***
// Port checker for the return and resume unit
`timescale 1ns/1ns
module prr_assertions (
  input wire logic        clk,           // Core clock
  input wire logic        rst_n,         // Reset, active low
  input wire logic        psel,          // APB select
  input wire logic        penable,       // APB access phase
  input wire logic        pwrite,        // APB write
  input wire logic [7:0]  paddr,         // APB address
  input wire logic [31:0] prdata,        // APB read data
  input wire logic        pready,        // APB ready
  input wire logic        pslverr,       // APB error
  input wire logic        pending_ops,   // Earlier work unfinished
  input wire logic        irq_pending,   // Interrupt waiting
  input wire logic        regset_free,   // Set free pulse
  input wire logic        regset_fill,   // Set reload pulse
  input wire logic        cache_discard, // Discard pulse
  input wire logic        idle,          // Idle state
  input wire logic        fault,         // Sticky fault
  input wire logic        mem_req,       // Memory request
  input wire logic [31:0] mem_addr,      // Memory address
  input wire logic        mem_ack        // Memory answer
);
  // ----------------------------------------------------------------
  // Properties
  // ----------------------------------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);
  sequence s_setup;
    psel && !penable;
  endsequence
  sequence s_answer;
    psel && penable && !pready ##1 pready;
  endsequence
  a_apb_wait: assert property (s_setup |=> s_answer) else $error("APB answer late");
  a_ready_pulse: assert property (pready |=> !pready) else $error("pready too long");
  a_err_zero: assert property (pslverr |-> pready && prdata == 32'h0000_0000)
    else $error("error answer carries data");
  a_req_hold: assert property (mem_req && !mem_ack |=> mem_req && $stable(mem_addr))
    else $error("memory request dropped");
  a_drain_first: assert property ($rose(mem_req) |-> !$past(pending_ops))
    else $error("read before drain");
  a_free_pulse: assert property (regset_free |=> !regset_free)
    else $error("free pulse too long");
  a_fill_pulse: assert property (regset_fill |=> !regset_fill)
    else $error("fill pulse too long");
  a_discard_only: assert property (cache_discard |-> !mem_req ##1 !cache_discard)
    else $error("discard with memory traffic");
  a_idle_hold: assert property (idle && !irq_pending |=> idle)
    else $error("idle left early");
  a_idle_wake: assert property (idle && irq_pending |-> ##[1:3] !idle)
    else $error("idle not left");
  a_fault_sticky: assert property (
    fault && !(psel && pwrite && paddr == prr_pkg::REG_STATUS) |=> fault)
    else $error("fault dropped");
endmodule : prr_assertions

bind prr_top prr_assertions chk_i (.*);

// *** tb/prr_mem_model.sv ***
// Memory model answering sequencer reads, prompt and slow in turn
`timescale 1ns/1ns
module prr_mem_model (
  input  wire logic        clk,       // Core clock
  input  wire logic        rst_n,     // Reset, active low
  input  wire logic        mem_req,   // Read request
  input  wire logic [31:0] mem_addr,  // Read byte address
  output logic             mem_ack,   // Answer, one cycle
  output logic [31:0]      mem_rdata  // Read data
);
  logic [31:0] mem_arr [0:63];
  logic [31:0] last;
  logic [1:0]  cnt;
  logic        slow;
  // Data outside the answer cycle is inverted so stale reads show
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      mem_ack <= 1'b0;
      mem_rdata <= 32'h0000_0000;
      last <= 32'h0000_0000;
      cnt <= 2'h0;
      slow <= 1'b0;
    end else if (mem_ack) begin
      mem_ack <= 1'b0;
      mem_rdata <= ~last;
    end else if (mem_req && cnt == (slow ? 2'h3 : 2'h0)) begin
      mem_ack <= 1'b1;
      mem_rdata <= mem_arr[mem_addr[7:2]];
      last <= mem_arr[mem_addr[7:2]];
      cnt <= 2'h0;
      slow <= ~slow;
    end else begin
      cnt <= mem_req ? cnt + 2'h1 : 2'h0;
      mem_rdata <= ~last;
    end
  end
endmodule : prr_mem_model

// *** tb/tb.sv ***
// Testbench for the return and resume unit
`timescale 1ns/1ns
module tb;
  logic        clk = 0, rst_n = 0, psel = 0, penable = 0, pwrite = 0, er;
  logic [7:0]  paddr = 8'h00;
  logic [31:0] pwdata = 32'h0000_0000, prdata, regset_addr, mem_addr, mem_rdata, rd;
  logic        pready, pslverr, pending_ops = 0, irq_pending = 0, regset_hit = 0;
  logic        fill_done = 0, regset_free, regset_fill, cache_discard, irq_check;
  logic        idle, fault, busy, mem_req, mem_ack;
  int          err_total = 0, n_compared = 0, n_free = 0, n_fill = 0, n_irq = 0, n_disc = 0;
  always #4 clk = ~clk;
  prr_top DUT (.*);
  prr_mem_model MEM (.*);
  // ----------------------------------------------------------------
  // Register set responder, pulse counters and tasks
  // ----------------------------------------------------------------
  always @(posedge clk) begin
    fill_done <= regset_fill;
    if (regset_free === 1'b1) n_free++;
    if (regset_fill === 1'b1) n_fill++;
    if (irq_check === 1'b1) n_irq++;
    if (cache_discard === 1'b1) n_disc++;
  end
  task automatic give_verdict;
    if (err_total == 0 && n_compared > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask : give_verdict
  task automatic quit_hung;
    err_total++;
    give_verdict;
  endtask : quit_hung
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    n_compared++;
    if (g !== e) begin
      err_total++;
      $display("BAD t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask : chk
  // Master holds the request until pready is seen at an edge
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    for (n = 0; n < 20; n++) begin
      @(posedge clk);
      if (pready === 1'b1) break;
    end
    if (n == 20) quit_hung;
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge clk);
  endtask : apb
  task automatic wait_done;
    int n;
    for (n = 0; n < 100; n++) begin
      apb(1'b0, prr_pkg::REG_STATUS, 32'h0000_0000);
      if (rd[0] === 1'b0) break;
    end
    if (n == 100) quit_hung;
  endtask : wait_done
  task automatic wait_idle(input logic v);
    int n;
    for (n = 0; idle !== v; n++) begin
      if (n == 200) quit_hung;
      @(posedge clk);
    end
  endtask : wait_idle
  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial begin
    logic [2:0]  s;
    logic        sup;
    logic        hlt;
    logic [31:0] epc;
    int          f0, l0, i0, d0;
    repeat (3) @(posedge clk);
    rst_n <= 1'b1;
    apb(1'b0, prr_pkg::REG_PROC, 32'h0000_0000);
    chk(rd, 32'h0000_0002);
    MEM.mem_arr[28] = 32'h0000_0003;
    MEM.mem_arr[29] = 32'h0000_5A5A;
    MEM.mem_arr[18] = 32'h0000_1237;
    // Eight codes in supervisor, then codes 1, 2 and 6 in user mode
    for (int k = 0; k < 11; k++) begin
      s = (k < 8) ? k[2:0] : (k == 8) ? 3'h1 : (k == 9) ? 3'h2 : 3'h6;
      sup = k < 8;
      hlt = sup && s == 3'h6;
      f0 = n_free;
      l0 = n_fill;
      i0 = n_irq;
      MEM.mem_arr[32] = 32'h0000_0040 | 32'(s);
      regset_hit <= s[0];
      apb(1'b1, prr_pkg::REG_PROC, sup ? 32'h0000_0002 : 32'h0000_0000);
      apb(1'b1, prr_pkg::REG_FRAME, 32'h0000_0080);
      apb(1'b1, prr_pkg::REG_ARITH, 32'h0000_0000);
      pending_ops <= 1'b1;
      apb(1'b1, prr_pkg::REG_COMMAND, 32'h0000_0001);
      repeat (6) begin
        @(posedge clk);
        chk(mem_req, 32'h0000_0000);
        chk(busy, 32'h0000_0001);
      end
      pending_ops <= 1'b0;
      if (hlt) begin
        wait_idle(1'b1);
        irq_pending <= 1'b1;
        wait_idle(1'b0);
        irq_pending <= 1'b0;
      end
      wait_done;
      apb(1'b0, prr_pkg::REG_FRAME, 32'h0000_0000);
      chk(rd, hlt ? 32'h0000_0080 : 32'h0000_0040);
      chk(regset_addr, hlt ? 32'h0000_0080 : 32'h0000_0040);
      apb(1'b0, prr_pkg::REG_INSTR, 32'h0000_0000);
      if (!hlt) chk(rd, 32'h0000_1234);
      apb(1'b0, prr_pkg::REG_ARITH, 32'h0000_0000);
      chk(rd, (s == 3'h1 || s == 3'h7) ? 32'h0000_5A5A : 32'h0000_0000);
      epc = !sup ? 0 : (s == 3'h1 || s == 3'h7) ? 3 : s == 3'h2 ? 0 : s == 3'h3 ? 1 : 2;
      apb(1'b0, prr_pkg::REG_PROC, 32'h0000_0000);
      chk(rd, epc);
      apb(1'b0, prr_pkg::REG_STATUS, 32'h0000_0000);
      chk(rd[11:8], s);
      chk(n_free - f0, 1);
      chk(n_fill - l0, (!hlt && !s[0]) ? 1 : 0);
      chk(n_irq - i0, hlt ? 2 : (sup && s == 3'h7) ? 1 : 0);
    end
    // Resume from user mode, with a plain operand, then a real bind
    apb(1'b1, prr_pkg::REG_OPERAND, 32'h0000_1230);
    for (int j = 0; j < 3; j++) begin
      d0 = n_disc;
      apb(1'b1, prr_pkg::REG_PROC, j == 0 ? 32'h0000_0000 : 32'h0000_0002);
      apb(1'b1, prr_pkg::REG_COMMAND, j == 1 ? 32'h0000_0002 : 32'h0000_0006);
      wait_done;
      apb(1'b0, prr_pkg::REG_STATUS, 32'h0000_0000);
      chk(rd[4:2], j == 0 ? 3'h5 : j == 1 ? 3'h3 : 3'h0);
      apb(1'b1, prr_pkg::REG_STATUS, 32'h0000_0004);
      chk(fault, 32'h0000_0000);
      apb(1'b0, prr_pkg::REG_PCB_BASE, 32'h0000_0000);
      chk(rd, j == 2 ? 32'h0000_1230 : 32'h0000_0000);
      chk(n_disc - d0, j == 2 ? 1 : 0);
    end
    apb(1'b1, prr_pkg::REG_INSTR, 32'hFFFF_FFFF);
    apb(1'b0, prr_pkg::REG_INSTR, 32'h0000_0000);
    chk(rd, 32'h0000_1234);
    apb(1'b0, 8'h20, 32'h0000_0000);
    chk(er, 32'h0000_0001);
    chk(rd, 32'h0000_0000);
    give_verdict;
  end
  initial begin
    repeat (50000) @(posedge clk);
    quit_hung;
  end
endmodule : tb
